// [src/tcm_slice_maps.v]
// One switch slice: double-buffered connection maps, map transfer and special-signal insertion masks.
//
// Notes on behaviour
// - A slice holds maps for two adjacent outputs, interpreted by size and slicing mode.
// - Map address is output and time slot; entry gives channel, slot, slice.
// - Standby map is read and written by the CPU; active map ignores writes.
// - A change request from pin or register copies all standby maps at frame boundary.
// - Four banks, each with channel, time slot and slice entries, active and standby.
// - Full-size unsliced: bank 0 even output, bank 2 odd; banks 1 and 3 mirror.
// - Half-size 4x sliced: four banks feed one output, bank 0 least significant pair.
// - Half-input modes ignore channel bit 7; bits 6 to 0 pick the channel.
// - In 2x sliced modes slice entry one picks the upper slice, zero the lower.
// - 136x34 4x mode: slices 0/1 give bits 0 to 3, slices 2/3 bits 4 to 7.
// - Transparent mode uses first channel entry, third bank for output 1 in full-output modes.
// - Reserved channel codes insert alarm, unequipped or a test pattern per time slot, nibble or bit pair.
// - Codes FF FE FD FC are domain 0; F7 F6 F5 F4 domain 1.
// - Alarm forces all ones; J0 carries the time slot number.
// - SDH unequipped forces zero, J0 carries slot number, H1 is 0x68.
// - Unequipped insertion regenerates the A1 and A2 framing bytes.
// - Unequipped B2 alternates between the H1 value and zero each frame.
// - Code FD gives SONET unequipped with H1 0x60 and matching B2.
// - Half-input modes ignore the code MSB, so 0x7F also means alarm.
// - In sliced modes inserted H1 bits follow their position in the byte.
// - A slice with output 0 transparent acts on a change request at once.
// - Reset gives channel 0xFE, time slot 0x05, slice zero in every entry.
`timescale 1ns/1ps
`include "tcm_map.vh"

module tcm_slice_maps #(
	parameter SLOTS = 48
) (
	input  wire                   core_clk_in,
	input  wire                   srst_in,
	input  wire                   cpu_cs_in,
	input  wire                   cpu_we_in,
	input  wire [`TCM_ADDR_W-1:0] cpu_addr_in,
	input  wire [7:0]             cpu_wdata_in,
	output reg  [7:0]             cpu_rdata_out,
	input  wire                   newcfg_pin_in,
	input  wire                   newcfg_reg_in,
	input  wire [1:0]             size_in,
	input  wire [1:0]             bitslice_in,
	input  wire                   quarter_mode_in,
	input  wire                   upper_pair_in,
	input  wire                   transparent0_in,
	input  wire                   transparent1_in,
	input  wire                   frame_boundary_in,
	input  wire [5:0]             slot_in,
	input  wire [2:0]             pos_in,
	input  wire [7:0]             pattern_dom0_in,
	input  wire [7:0]             pattern_dom1_in,
	output reg  [31:0]            sel_channel_out,
	output reg  [31:0]            sel_timeslot_out,
	output reg  [3:0]             sel_upper_slice_out,
	output reg  [7:0]             insert_mask0_out,
	output reg  [7:0]             insert_data0_out,
	output reg  [7:0]             insert_mask1_out,
	output reg  [7:0]             insert_data1_out,
	output reg                    transparent0_out,
	output reg                    transparent1_out,
	output reg  [7:0]             trans_channel0_out,
	output reg  [7:0]             trans_channel1_out,
	output reg                    pending_out,
	output reg                    transfer_out
);

	localparam DEPTH = 4 * SLOTS;

	localparam MODE_HALF_HALF_X1    = 4'h0;
	localparam MODE_HALF_HALF_X2    = 4'h1;
	localparam MODE_HALF_HALF_X4    = 4'h2;
	localparam MODE_HALF_FULL_X1    = 4'h3;
	localparam MODE_HALF_FULL_X2    = 4'h4;
	localparam MODE_FULL_HALF_X1    = 4'h5;
	localparam MODE_FULL_HALF_X2    = 4'h6;
	localparam MODE_FULL_FULL_X1    = 4'h7;
	localparam MODE_FULL_QUARTER_X4 = 4'h8;

	reg [7:0] sb_chan [0:DEPTH-1];
	reg [7:0] sb_ts   [0:DEPTH-1];
	reg [7:0] sb_slc  [0:DEPTH-1];
	reg [7:0] ac_chan [0:DEPTH-1];
	reg [7:0] ac_ts   [0:DEPTH-1];
	reg [7:0] ac_slc  [0:DEPTH-1];

	reg       pin_s1_reg;
	reg       pin_s2_reg;
	reg       pin_s3_reg;
	reg       pin_level_reg;
	reg       pending_reg;
	reg       b2_phase_reg;

	reg [3:0] mode;
	reg       half_in;
	reg       mirror_pairs;
	reg       full_out;
	reg       pin_rise;
	reg       request;
	reg       xfer;
	reg [7:0] rd_value;
	reg [7:0] wr_idx;
	reg [7:0] mirror_idx;
	reg       wr_mirror;
	reg       addr_ok;
	reg [7:0] look_chan [0:3];
	reg       bank_special [0:3];
	reg       bank_domain [0:3];
	reg [1:0] bank_kind [0:3];
	reg [7:0] bank_pattern [0:3];
	reg [7:0] mask0;
	reg [7:0] data0;
	reg [7:0] mask1;
	reg [7:0] data1;
	reg [2:0] sel;
	reg [31:0] chan_next;
	reg [31:0] ts_next;
	reg [3:0]  slc_next;

	wire [7:0] bank_byte [0:3];

	integer i;
	integer b;

	// Flat index of a bank and time slot within one map array.
	function [7:0] map_index;
		input [1:0] bank;
		input [5:0] slot;
		begin
			map_index = {bank, 6'h00} - {2'h0, bank, 4'h0} + {2'h0, slot};
		end
	endfunction

	// Bank that governs one bit of an output byte: {valid, bank}.
	function [2:0] bank_for_bit;
		input [3:0] md;
		input       out1;
		input [2:0] bitpos;
		input       upper;
		begin
			case (md)
				MODE_HALF_HALF_X1, MODE_FULL_HALF_X1: bank_for_bit = out1 ? 3'h0 : 3'h4;
				MODE_HALF_FULL_X1, MODE_FULL_FULL_X1: bank_for_bit = out1 ? 3'h6 : 3'h4;
				MODE_HALF_HALF_X2: bank_for_bit = out1 ? 3'h0 : {2'b10, bitpos[2]};
				MODE_HALF_FULL_X2: bank_for_bit = {1'b1, out1, bitpos[2]};
				MODE_FULL_HALF_X2: bank_for_bit = out1 ? 3'h0 : {1'b1, bitpos[2], 1'b0};
				MODE_HALF_HALF_X4: bank_for_bit = out1 ? 3'h0 : {1'b1, bitpos[2:1]};
				MODE_FULL_QUARTER_X4: begin
					if (!out1 && (bitpos[2] == upper))
						bank_for_bit = {1'b1, bitpos[1], 1'b0};
					else
						bank_for_bit = 3'h0;
				end
				default:                bank_for_bit = 3'h0;
			endcase
		end
	endfunction

	// Mode decode from the size and slicing controls.
	always @* begin
		if (quarter_mode_in)
			mode = MODE_FULL_QUARTER_X4;
		else begin
			case ({bitslice_in, size_in})
				4'h0:    mode = MODE_HALF_HALF_X1;
				4'h1:    mode = MODE_HALF_FULL_X1;
				4'h2:    mode = MODE_FULL_HALF_X1;
				4'h3:    mode = MODE_FULL_FULL_X1;
				4'h4:    mode = MODE_HALF_HALF_X2;
				4'h5:    mode = MODE_HALF_FULL_X2;
				4'h6:    mode = MODE_FULL_HALF_X2;
				4'h8:    mode = MODE_HALF_HALF_X4;
				default: mode = MODE_HALF_HALF_X1;
			endcase
		end
		half_in = (mode == MODE_HALF_HALF_X1) || (mode == MODE_HALF_HALF_X2) || (mode == MODE_HALF_HALF_X4) ||
			(mode == MODE_HALF_FULL_X1) || (mode == MODE_HALF_FULL_X2);
		mirror_pairs = (mode == MODE_HALF_HALF_X1) || (mode == MODE_HALF_FULL_X1) ||
			(mode == MODE_FULL_HALF_X1) || (mode == MODE_FULL_FULL_X1) || (mode == MODE_FULL_HALF_X2) ||
			(mode == MODE_FULL_QUARTER_X4);
		full_out = (mode == MODE_HALF_FULL_X1) || (mode == MODE_HALF_FULL_X2) || (mode == MODE_FULL_FULL_X1);
	end

	// Request detection and the transfer point.
	always @* begin
		pin_rise = (pin_s2_reg == pin_s3_reg) && pin_s3_reg && !pin_level_reg;
		request  = pin_rise || newcfg_reg_in;
		xfer     = pending_reg && (frame_boundary_in || transparent0_in);
	end

	// CPU address decode and read data selection.
	always @* begin
		addr_ok    = (cpu_addr_in[`TCM_ADDR_SLOT_HI:`TCM_ADDR_SLOT_LO] < SLOTS) &&
			(cpu_addr_in[`TCM_ADDR_TYPE_HI:`TCM_ADDR_TYPE_LO] != 2'h3);
		wr_idx     = map_index(cpu_addr_in[`TCM_ADDR_BANK_HI:`TCM_ADDR_BANK_LO],
			cpu_addr_in[`TCM_ADDR_SLOT_HI:`TCM_ADDR_SLOT_LO]);
		mirror_idx = map_index({cpu_addr_in[`TCM_ADDR_BANK_HI], 1'b1},
			cpu_addr_in[`TCM_ADDR_SLOT_HI:`TCM_ADDR_SLOT_LO]);
		wr_mirror  = mirror_pairs && !cpu_addr_in[`TCM_ADDR_BANK_LO];
		rd_value   = 8'h00;
		if (addr_ok) begin
			case ({cpu_addr_in[`TCM_ADDR_MAP_BIT], cpu_addr_in[`TCM_ADDR_TYPE_HI:`TCM_ADDR_TYPE_LO]})
				{`TCM_MAP_STANDBY, `TCM_TYPE_CHANNEL}:  rd_value = sb_chan[wr_idx];
				{`TCM_MAP_STANDBY, `TCM_TYPE_TIMESLOT}: rd_value = sb_ts[wr_idx];
				{`TCM_MAP_STANDBY, `TCM_TYPE_SLICE}:    rd_value = sb_slc[wr_idx];
				{`TCM_MAP_ACTIVE, `TCM_TYPE_CHANNEL}:   rd_value = ac_chan[wr_idx];
				{`TCM_MAP_ACTIVE, `TCM_TYPE_TIMESLOT}:  rd_value = ac_ts[wr_idx];
				{`TCM_MAP_ACTIVE, `TCM_TYPE_SLICE}:     rd_value = ac_slc[wr_idx];
				default:                                rd_value = 8'h00;
			endcase
		end
	end

	// Per-bank lookup of the active map for the current output slot.
	always @* begin
		chan_next = 32'h0000_0000;
		ts_next   = 32'h0000_0000;
		slc_next  = 4'h0;
		for (b = 0; b < 4; b = b + 1) begin
			look_chan[b] = ac_chan[map_index(b[1:0], slot_in)];
			if (half_in)
				look_chan[b] = {1'b1, look_chan[b][6:0]};
			bank_special[b] = (look_chan[b][7:4] == `TCM_SPC_NIBBLE) &&
				look_chan[b][`TCM_SPC_MARK_BIT];
			bank_domain[b]  = !look_chan[b][`TCM_SPC_DOM_BIT];
			bank_kind[b]    = look_chan[b][1:0];
			bank_pattern[b] = bank_domain[b] ? pattern_dom1_in : pattern_dom0_in;
			chan_next[b*8 +: 8] = half_in ? {1'b0, look_chan[b][6:0]} : look_chan[b];
			ts_next[b*8 +: 8]   = ac_ts[map_index(b[1:0], slot_in)];
			slc_next[b]         = ac_slc[map_index(b[1:0], slot_in)][0];
		end
	end

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : gen_bank
			tcm_special_byte u_special (
				.kind_in     (bank_kind[g]),
				.pos_in      (pos_in),
				.slot_in     (slot_in),
				.b2_phase_in (b2_phase_reg),
				.pattern_in  (bank_pattern[g]),
				.byte_out    (bank_byte[g])
			);
		end
	endgenerate

	// Each bit of each output takes the special byte bit of the bank that owns it.
	always @* begin
		mask0 = 8'h00;
		data0 = 8'h00;
		mask1 = 8'h00;
		data1 = 8'h00;
		sel   = 3'h0;
		for (i = 0; i < 8; i = i + 1) begin
			sel = bank_for_bit(mode, 1'b0, i[2:0], upper_pair_in);
			if (sel[2] && bank_special[sel[1:0]]) begin
				mask0[i] = 1'b1;
				data0[i] = bank_byte[sel[1:0]][i];
			end
			sel = bank_for_bit(mode, 1'b1, i[2:0], upper_pair_in);
			if (sel[2] && bank_special[sel[1:0]]) begin
				mask1[i] = 1'b1;
				data1[i] = bank_byte[sel[1:0]][i];
			end
		end
	end

	// Synchroniser, pending request, frame phase and CPU read data.
	always @(posedge core_clk_in) begin
		if (srst_in) begin
			pin_s1_reg    <= 1'b0;
			pin_s2_reg    <= 1'b0;
			pin_s3_reg    <= 1'b0;
			pin_level_reg <= 1'b0;
			pending_reg   <= 1'b0;
			b2_phase_reg  <= 1'b0;
			cpu_rdata_out <= 8'h00;
			pending_out   <= 1'b0;
			transfer_out  <= 1'b0;
		end else begin
			pin_s1_reg <= newcfg_pin_in;
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
			if (pin_s2_reg == pin_s3_reg)
				pin_level_reg <= pin_s3_reg;
			// A request in the transfer cycle stays pending, so it is never lost.
			pending_reg  <= request || (pending_reg && !xfer);
			pending_out  <= request || (pending_reg && !xfer);
			transfer_out <= xfer;
			if (frame_boundary_in)
				b2_phase_reg <= !b2_phase_reg;
			if (cpu_cs_in && !cpu_we_in)
				cpu_rdata_out <= rd_value;
		end
	end

	// Map storage: CPU writes to standby, whole-map copy at the transfer point.
	always @(posedge core_clk_in) begin
		if (srst_in) begin
			for (i = 0; i < DEPTH; i = i + 1) begin
				sb_chan[i] <= `TCM_RST_CHANNEL;
				sb_ts[i]   <= `TCM_RST_TIMESLOT;
				sb_slc[i]  <= `TCM_RST_SLICE;
				ac_chan[i] <= `TCM_RST_CHANNEL;
				ac_ts[i]   <= `TCM_RST_TIMESLOT;
				ac_slc[i]  <= `TCM_RST_SLICE;
			end
		end else begin
			if (xfer) begin
				for (i = 0; i < DEPTH; i = i + 1) begin
					ac_chan[i] <= sb_chan[i];
					ac_ts[i]   <= sb_ts[i];
					ac_slc[i]  <= sb_slc[i];
				end
			end
			// Writes aimed at the active map fall through with no effect.
			if (cpu_cs_in && cpu_we_in && addr_ok &&
				(cpu_addr_in[`TCM_ADDR_MAP_BIT] == `TCM_MAP_STANDBY)) begin
				case (cpu_addr_in[`TCM_ADDR_TYPE_HI:`TCM_ADDR_TYPE_LO])
					`TCM_TYPE_CHANNEL: begin
						sb_chan[wr_idx] <= cpu_wdata_in;
						if (wr_mirror)
							sb_chan[mirror_idx] <= cpu_wdata_in;
					end
					`TCM_TYPE_TIMESLOT: begin
						sb_ts[wr_idx] <= cpu_wdata_in;
						if (wr_mirror)
							sb_ts[mirror_idx] <= cpu_wdata_in;
					end
					`TCM_TYPE_SLICE: begin
						sb_slc[wr_idx] <= cpu_wdata_in;
						if (wr_mirror)
							sb_slc[mirror_idx] <= cpu_wdata_in;
					end
					default: begin
					end
				endcase
			end
		end
	end

	// Registered switching controls for the datapath.
	always @(posedge core_clk_in) begin
		if (srst_in) begin
			sel_channel_out     <= 32'h0000_0000;
			sel_timeslot_out    <= 32'h0000_0000;
			sel_upper_slice_out <= 4'h0;
			insert_mask0_out    <= 8'h00;
			insert_data0_out    <= 8'h00;
			insert_mask1_out    <= 8'h00;
			insert_data1_out    <= 8'h00;
			transparent0_out    <= 1'b0;
			transparent1_out    <= 1'b0;
			trans_channel0_out  <= 8'h00;
			trans_channel1_out  <= 8'h00;
		end else begin
			sel_channel_out     <= chan_next;
			sel_timeslot_out    <= ts_next;
			sel_upper_slice_out <= slc_next;
			insert_mask0_out    <= mask0;
			insert_data0_out    <= data0;
			insert_mask1_out    <= mask1;
			insert_data1_out    <= data1;
			transparent0_out    <= transparent0_in;
			transparent1_out    <= full_out ? transparent1_in : transparent0_in;
			trans_channel0_out  <= ac_chan[map_index(2'h0, 6'h00)];
			trans_channel1_out  <= full_out ? ac_chan[map_index(2'h2, 6'h00)] :
				ac_chan[map_index(2'h0, 6'h00)];
		end
	end

endmodule

// [common/tcm_map.vh]
// Address layout, entry reset values, special channel codes and overhead constants of the connection maps.
`ifndef TCM_MAP_VH
`define TCM_MAP_VH

// CPU address fields: {map_select, entry_type[1:0], bank[1:0], time_slot[5:0]}.
`define TCM_ADDR_W         11
`define TCM_ADDR_MAP_BIT   10
`define TCM_ADDR_TYPE_HI   9
`define TCM_ADDR_TYPE_LO   8
`define TCM_ADDR_BANK_HI   7
`define TCM_ADDR_BANK_LO   6
`define TCM_ADDR_SLOT_HI   5
`define TCM_ADDR_SLOT_LO   0

// Entry type codes in the type field.
`define TCM_TYPE_CHANNEL   2'h0
`define TCM_TYPE_TIMESLOT  2'h1
`define TCM_TYPE_SLICE     2'h2

// Map select bit values.
`define TCM_MAP_STANDBY    1'b0
`define TCM_MAP_ACTIVE     1'b1

// Entry reset values.
`define TCM_RST_CHANNEL    8'hFE
`define TCM_RST_TIMESLOT   8'h05
`define TCM_RST_SLICE      8'h00

// Special channel codes: upper nibble, marker bit and kind in the low bits.
`define TCM_SPC_NIBBLE     4'hF
`define TCM_SPC_DOM_BIT    3
`define TCM_SPC_MARK_BIT   2
`define TCM_KIND_AIS       2'h3
`define TCM_KIND_SDH_UNEQ  2'h2
`define TCM_KIND_SONET_UNEQ 2'h1
`define TCM_KIND_PATTERN   2'h0

// Overhead position codes on the frame position input.
`define TCM_POS_DATA       3'h0
`define TCM_POS_A1         3'h1
`define TCM_POS_A2         3'h2
`define TCM_POS_J0         3'h3
`define TCM_POS_H1         3'h4
`define TCM_POS_B2         3'h5

// Inserted byte values.
`define TCM_BYTE_ONES      8'hFF
`define TCM_BYTE_ZERO      8'h00
`define TCM_H1_SDH         8'h68
`define TCM_H1_SONET       8'h60
`define TCM_A1_VALUE       8'hF6
`define TCM_A2_VALUE       8'h28

`endif

// [src/tcm_special_byte.v]
// Byte generator for alarm, unequipped and test pattern insertion.
`timescale 1ns/1ps
`include "tcm_map.vh"

module tcm_special_byte (
	input  wire [1:0] kind_in,
	input  wire [2:0] pos_in,
	input  wire [5:0] slot_in,
	input  wire       b2_phase_in,
	input  wire [7:0] pattern_in,
	output reg  [7:0] byte_out
);

	reg [7:0] h1_value;

	always @* begin
		h1_value = (kind_in == `TCM_KIND_SONET_UNEQ) ? `TCM_H1_SONET : `TCM_H1_SDH;
		byte_out = `TCM_BYTE_ZERO;
		case (kind_in)
			`TCM_KIND_AIS: begin
				if (pos_in == `TCM_POS_J0)
					byte_out = {2'h0, slot_in};
				else
					byte_out = `TCM_BYTE_ONES;
			end
			`TCM_KIND_SDH_UNEQ, `TCM_KIND_SONET_UNEQ: begin
				case (pos_in)
					`TCM_POS_A1: byte_out = `TCM_A1_VALUE;
					`TCM_POS_A2: byte_out = `TCM_A2_VALUE;
					`TCM_POS_J0: byte_out = {2'h0, slot_in};
					`TCM_POS_H1: byte_out = h1_value;
					`TCM_POS_B2: byte_out = b2_phase_in ? h1_value : `TCM_BYTE_ZERO;
					default:     byte_out = `TCM_BYTE_ZERO;
				endcase
			end
			default: byte_out = pattern_in;
		endcase
	end

endmodule

// [bench/tcm_slice_maps_chk.sv]
// Concurrent checks on map access and standby-to-active transfer of one slice.
`timescale 1ns/1ps
module tcm_slice_maps_chk #(
	parameter SLOTS = 48
) (
	input wire        core_clk_in,
	input wire        srst_in,
	input wire        cpu_cs_in,
	input wire        cpu_we_in,
	input wire [10:0] cpu_addr_in,
	input wire [7:0]  cpu_wdata_in,
	input wire [7:0]  cpu_rdata_out,
	input wire        newcfg_reg_in,
	input wire        frame_boundary_in,
	input wire        transparent0_in,
	input wire        pending_out,
	input wire        transfer_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (srst_in);
	sequence s_std_write;
		cpu_cs_in && cpu_we_in && !cpu_addr_in[10] && cpu_addr_in[9:8] != 2'h3 && cpu_addr_in[5:0] < SLOTS;
	endsequence
	sequence s_same_read;
		cpu_cs_in && !cpu_we_in && cpu_addr_in == $past(cpu_addr_in);
	endsequence
	AST_WRITE_READ: assert property (s_std_write ##1 s_same_read |=> cpu_rdata_out == $past(cpu_wdata_in, 2))
		else $error("standby read differs from write");
	AST_UNMAPPED_READ: assert property (cpu_cs_in && !cpu_we_in && cpu_addr_in[9:8] == 2'h3 |=> cpu_rdata_out == 8'h00)
		else $error("unmapped read not zero");
	AST_RESET_CLEAR: assert property ($fell(srst_in) |-> !pending_out && !transfer_out && cpu_rdata_out == 8'h00)
		else $error("outputs not cleared by reset");
	AST_REQ_PENDS: assert property (newcfg_reg_in |-> ##[1:3] (pending_out || transfer_out))
		else $error("request not held pending");
	AST_BOUNDARY_COPY: assert property (pending_out && frame_boundary_in |-> ##1 transfer_out)
		else $error("boundary copy missed");
	AST_TRANSP_COPY: assert property (pending_out && transparent0_in |-> ##1 transfer_out)
		else $error("transparent copy missed");
	AST_XFER_CAUSE: assert property (transfer_out |-> $past(frame_boundary_in) || $past(transparent0_in))
		else $error("transfer without copy point");
	AST_XFER_PEND: assert property (transfer_out |-> $past(pending_out))
		else $error("transfer without pending request");
endmodule

bind tcm_slice_maps tcm_slice_maps_chk #(.SLOTS(SLOTS)) u_chk (
	.core_clk_in(core_clk_in), .srst_in(srst_in), .cpu_cs_in(cpu_cs_in), .cpu_we_in(cpu_we_in),
	.cpu_addr_in(cpu_addr_in), .cpu_wdata_in(cpu_wdata_in), .cpu_rdata_out(cpu_rdata_out),
	.newcfg_reg_in(newcfg_reg_in), .frame_boundary_in(frame_boundary_in), .transparent0_in(transparent0_in),
	.pending_out(pending_out), .transfer_out(transfer_out)
);

// [bench/tcm_frame_src.sv]
// Frame timing source for the framer side: overhead position, slot number and boundary pulse.
`timescale 1ns/1ps
`include "tcm_map.vh"
module tcm_frame_src #(
	parameter FRAME_LEN = 16
) (
	input  wire       core_clk_in,
	input  wire       srst_in,
	input  wire       run_in,
	input  wire [5:0] slot_sel_in,
	output reg  [2:0] pos_out,
	output reg  [5:0] slot_out,
	output reg        boundary_out
);
	localparam [7:0] LAST = FRAME_LEN - 1;
	reg [7:0] cnt_reg;
	// Frames stop while idle so that a pending request is seen waiting for the next boundary.
	always @(posedge core_clk_in) begin
		slot_out <= slot_sel_in;
		if (srst_in || !run_in) begin
			cnt_reg      <= 8'h00;
			pos_out      <= `TCM_POS_DATA;
			boundary_out <= 1'b0;
		end else begin
			cnt_reg      <= (cnt_reg == LAST) ? 8'h00 : cnt_reg + 8'h01;
			boundary_out <= (cnt_reg == 8'h01);
			pos_out      <= (cnt_reg == 8'h00) ? `TCM_POS_A1 : (cnt_reg == 8'h01) ? `TCM_POS_A2 :
				(cnt_reg == 8'h02) ? `TCM_POS_J0 : (cnt_reg == 8'h03) ? `TCM_POS_H1 :
				(cnt_reg == 8'h04) ? `TCM_POS_B2 : `TCM_POS_DATA;
		end
	end
endmodule

// [bench/tcm_slice_maps_tb.sv]
// Self-checking testbench for one connection map slice.
`timescale 1ns/1ps
`include "tcm_map.vh"
module tcm_slice_maps_tb;
	localparam [7:0] PAT0 = 8'hA5;
	localparam [7:0] PAT1 = 8'h3C;
	reg         core_clk_in, srst_in, cs, we, pin, req, tr0, tr1, run, qm, up;
	reg  [10:0] addr;
	reg  [7:0]  wdata, v1;
	reg  [1:0]  size, bs;
	reg  [5:0]  slot_sel;
	wire [7:0]  rdata, m0, d0, m1, d1, tc0, tc1;
	wire [2:0]  pos_in;
	wire [5:0]  slot_in;
	wire [31:0] sel_ch;
	wire [3:0]  sel_up;
	wire        fb, t1o, pend, xfer_o;
	integer     fail_count, checks, i, n;
	tcm_frame_src #(.FRAME_LEN(16)) u_frame (.core_clk_in(core_clk_in), .srst_in(srst_in), .run_in(run),
		.slot_sel_in(slot_sel), .pos_out(pos_in), .slot_out(slot_in), .boundary_out(fb));
	tcm_slice_maps #(.SLOTS(48)) uut (.core_clk_in(core_clk_in), .srst_in(srst_in), .cpu_cs_in(cs),
		.cpu_we_in(we), .cpu_addr_in(addr), .cpu_wdata_in(wdata), .cpu_rdata_out(rdata), .newcfg_pin_in(pin),
		.newcfg_reg_in(req), .size_in(size), .bitslice_in(bs), .quarter_mode_in(qm), .upper_pair_in(up),
		.transparent0_in(tr0), .transparent1_in(tr1), .frame_boundary_in(fb), .slot_in(slot_in), .pos_in(pos_in),
		.pattern_dom0_in(PAT0), .pattern_dom1_in(PAT1), .sel_channel_out(sel_ch), .sel_timeslot_out(),
		.sel_upper_slice_out(sel_up), .insert_mask0_out(m0), .insert_data0_out(d0), .insert_mask1_out(m1),
		.insert_data1_out(d1), .transparent0_out(), .transparent1_out(t1o), .trans_channel0_out(tc0),
		.trans_channel1_out(tc1), .pending_out(pend), .transfer_out(xfer_o));
	initial begin
		core_clk_in = 1'b0;
		forever #50 core_clk_in = ~core_clk_in;
	end
	function [10:0] a(input m, input [1:0] t, input [1:0] b, input [5:0] s);
		a = {m, t, b, s};
	endfunction
	function [7:0] code_of(input [2:0] k);
		code_of = 8'hFF - {5'h00, k} - (k[2] ? 8'h04 : 8'h00);
	endfunction
	function [2:0] pv(input [1:0] j);
		pv = (j == 2'h0) ? `TCM_POS_DATA : (j == 2'h1) ? `TCM_POS_J0 : (j == 2'h2) ? `TCM_POS_H1 : `TCM_POS_A1;
	endfunction
	function [7:0] exp_byte(input [7:0] c, input [2:0] p, input [5:0] s);
		if (c[1:0] == 2'h0)
			exp_byte = c[3] ? PAT0 : PAT1;
		else if (p == `TCM_POS_J0)
			exp_byte = {2'b00, s};
		else if (c[1:0] == 2'h3)
			exp_byte = 8'hFF;
		else if (p == `TCM_POS_H1)
			exp_byte = c[0] ? 8'h60 : 8'h68;
		else
			exp_byte = (p == `TCM_POS_A1) ? 8'hF6 : 8'h00;
	endfunction
	task check(input [31:0] seen, input [31:0] exp);
		begin
			checks = checks + 1;
			if (seen !== exp) begin
				fail_count = fail_count + 1;
				$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task summarize;
		begin
			$display("checks %0d mismatches %0d", checks, fail_count);
			if (fail_count == 0 && checks > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask
	// A write is followed at once by a read of the same place, so read-back needs no idle cycle.
	task wrrd(input [10:0] ad, input [7:0] dat, input [7:0] exp);
		begin
			@(posedge core_clk_in);
			{cs, we} <= 2'b11;
			addr <= ad;
			wdata <= dat;
			@(posedge core_clk_in);
			we <= 1'b0;
			@(posedge core_clk_in);
			cs <= 1'b0;
			#1;
			check(rdata, exp);
		end
	endtask
	task rd(input [10:0] ad, input [7:0] exp);
		begin
			@(posedge core_clk_in);
			{cs, we} <= 2'b10;
			addr <= ad;
			@(posedge core_clk_in);
			cs <= 1'b0;
			#1;
			check(rdata, exp);
		end
	endtask
	task look(input [5:0] s, input [2:0] p);
		begin
			slot_sel <= s;
			run <= 1'b1;
			n = 0;
			@(posedge core_clk_in);
			#1;
			while ((pos_in !== p || slot_in !== s) && n < 64) begin
				@(posedge core_clk_in);
				#1;
				n = n + 1;
			end
			@(posedge core_clk_in);
			#1;
		end
	endtask
	task xfer(input use_pin, input frames);
		begin
			@(posedge core_clk_in);
			run <= 1'b0;
			pin <= use_pin;
			req <= !use_pin;
			@(posedge core_clk_in);
			req <= 1'b0;
			#1;
			n = 0;
			if (frames) begin
				repeat (8) @(posedge core_clk_in);
				#1;
				check({pend, xfer_o}, 2'b10);
				run <= 1'b1;
			end
			while (xfer_o !== 1'b1 && n < 100) begin
				@(posedge core_clk_in);
				#1;
				n = n + 1;
			end
			pin <= 1'b0;
		end
	endtask
	initial begin
		#2000000;
		fail_count = fail_count + 1;
		summarize;
	end
	initial begin
		fail_count = 0;
		checks = 0;
		{cs, we, pin, req, tr0, tr1, run, qm, up} = 9'h000;
		{addr, wdata, slot_sel} = 25'h0000000;
		{size, bs} = 4'hC;
		srst_in = 1'b1;
		repeat (2) @(posedge core_clk_in);
		srst_in <= 1'b0;
		for (i = 0; i < 6; i = i + 1)
			rd(a(i[0], i[2:1], 2'h3, 6'h2F), (i < 2) ? 8'hFE : (i < 4) ? 8'h05 : 8'h00);
		rd(a(1'b0, 2'h3, 2'h0, 6'h00), 8'h00);
		rd(a(1'b0, 2'h0, 2'h0, 6'h30), 8'h00);
		wrrd(a(1'b0, 2'h0, 2'h1, 6'h03), 8'h12, 8'h12);
		wrrd(a(1'b1, 2'h0, 2'h1, 6'h03), 8'h34, 8'hFE);
		xfer(1'b1, 1'b1);
		check(n < 100, 1'b1);
		rd(a(1'b1, 2'h0, 2'h1, 6'h03), 8'h12);
		$display("test map access done");
		for (i = 0; i < 8; i = i + 1) begin
			wrrd(a(1'b0, 2'h0, 2'h0, i[5:0]), code_of(i[2:0]), code_of(i[2:0]));
			rd(a(1'b0, 2'h0, 2'h1, i[5:0]), code_of(i[2:0]));
		end
		xfer(1'b0, 1'b1);
		for (i = 0; i < 32; i = i + 1) begin
			look({3'b000, i[4:2]}, pv(i[1:0]));
			if (code_of(i[4:2]) % 4 != 0 || i[1:0] == 2'h0)
				check({m0, d0}, {8'hFF, exp_byte(code_of(i[4:2]), pv(i[1:0]), {3'b000, i[4:2]})});
			check({m1, d1}, {8'hFF, exp_byte(8'hFE, pv(i[1:0]), {3'b000, i[4:2]})});
		end
		look(6'h01, `TCM_POS_B2);
		v1 = d0;
		look(6'h01, `TCM_POS_B2);
		check({v1 ^ d0, v1 & d0}, {8'h68, 8'h00});
		$display("test special insertion done");
		size <= 2'h0;
		wrrd(a(1'b0, 2'h0, 2'h0, 6'h0A), 8'h7F, 8'h7F);
		wrrd(a(1'b0, 2'h0, 2'h0, 6'h0B), 8'h85, 8'h85);
		xfer(1'b0, 1'b1);
		look(6'h0A, `TCM_POS_DATA);
		check({m0, d0, m1}, {8'hFF, 8'hFF, 8'h00});
		look(6'h0B, `TCM_POS_DATA);
		check(sel_ch[7:0], 8'h05);
		bs <= 2'h2;
		look(6'h0C, `TCM_POS_H1);
		check({m0, d0}, {8'hFF, 8'h68});
		bs <= 2'h1;
		wrrd(a(1'b0, 2'h2, 2'h0, 6'h0D), 8'h01, 8'h01);
		xfer(1'b0, 1'b1);
		look(6'h0D, `TCM_POS_DATA);
		check(sel_up[0], 1'b1);
		$display("test modes done");
		{size, bs, tr0, tr1} <= 6'h33;
		wrrd(a(1'b0, 2'h0, 2'h0, 6'h00), 8'h21, 8'h21);
		wrrd(a(1'b0, 2'h0, 2'h2, 6'h00), 8'h22, 8'h22);
		xfer(1'b0, 1'b0);
		check(n <= 2, 1'b1);
		// The channel outputs sample the active map at the copy edge, so they show the new entries one edge later.
		@(posedge core_clk_in);
		#1;
		check({t1o, tc0, tc1}, {1'b1, 8'h21, 8'h22});
		$display("test transparent done");
		{qm, up} <= 2'b10;
		look(6'h0C, `TCM_POS_H1);
		check({m0, d0, m1}, {8'h0F, 8'h08, 8'h00});
		up <= 1'b1;
		look(6'h0C, `TCM_POS_H1);
		check({m0, d0}, {8'hF0, 8'h60});
		$display("test quarter mode done");
		summarize;
	end
endmodule
